// [shared/priv_pkg.sv]
// Purpose: constants and carriers for privileged scratch storage
// Assumes: single CPU clock, register file ports driven by issue logic
// Notes: scheduling limits on firmware are not interlocked
// Functional notes
// - privileged mode with shadow enable steers regs 8-14 and 25 to shadows.
// - 24 scratch registers, read by move-from, written by move-to.
// - scratch read value usable one cycle after the read issues.
// - error status read unlocks status and address; read address first.
// - trapped memory op leaves internal writes in 0,1; return address correct.
package priv_pkg;
    localparam int DATA_W = 64;
    localparam int GPR_ADDR_W = 5;
    localparam int SCRATCH_COUNT = 24;
    localparam int SCRATCH_ADDR_W = 5;
    localparam int SHADOW_COUNT = 8;
    localparam int SHADOW_IDX_W = 3;
    localparam logic [GPR_ADDR_W-1:0] SHADOW_LOW_REG = 5'h08;
    localparam logic [GPR_ADDR_W-1:0] SHADOW_HIGH_REG = 5'h0E;
    localparam logic [GPR_ADDR_W-1:0] SHADOW_EXTRA_REG = 5'h19;
    localparam logic [SHADOW_IDX_W-1:0] SHADOW_EXTRA_IDX = 3'h7;
    localparam logic [DATA_W-1:0] SCRATCH_RESET = 64'h0000000000000000;
    localparam logic [DATA_W-1:0] ADDR_RESET = 64'h0000000000000000;
    localparam int SCRATCH_READ_LATENCY = 1;
    localparam int SDE_RESET = 1;

    typedef struct packed {
        logic valid;
        logic [GPR_ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } gpr_write_t;

    typedef struct packed {
        logic valid;
        logic [SHADOW_IDX_W-1:0] idx;
    } shadow_sel_t;

    typedef struct packed {
        logic readEn;
        logic writeEn;
        logic [SCRATCH_ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } scratch_req_t;
endpackage : priv_pkg

// [rtl/shadow_steer.sv]
`timescale 1ns/1ps
// Purpose: map a general register number to a shadow slot
// Assumes: purely combinational, same clock domain as caller
// Notes: slot 7 holds register 25
module shadow_steer
(
    input wire logic [priv_pkg::GPR_ADDR_W-1:0] regAddr,
    input wire logic privMode,
    input wire logic shadowEnable,
    output priv_pkg::shadow_sel_t sel
);
    always_comb
    begin
        sel.valid = 1'b0;
        sel.idx = '0;
        if (privMode && shadowEnable)
        begin
            if (regAddr >= priv_pkg::SHADOW_LOW_REG && regAddr <= priv_pkg::SHADOW_HIGH_REG)
            begin
                sel.valid = 1'b1;
                sel.idx = priv_pkg::SHADOW_IDX_W'(regAddr - priv_pkg::SHADOW_LOW_REG);
            end
            else if (regAddr == priv_pkg::SHADOW_EXTRA_REG)
            begin
                sel.valid = 1'b1;
                sel.idx = priv_pkg::SHADOW_EXTRA_IDX;
            end
        end
    end
endmodule : shadow_steer

// [rtl/priv_scratch_regs.sv]
`timescale 1ns/1ps
// Purpose: shadow register overlay, scratch bank, trap return address capture
// Assumes: issue pipeline presents register numbers and privileged mode
// Notes: firmware scheduling limits are not checked here
module priv_scratch_regs
#(
    parameter int SCRATCH_COUNT = priv_pkg::SCRATCH_COUNT
)
(
    input wire logic clock,
    input wire logic arst_n,
    input wire logic privMode,
    input wire logic shadowEnableWrite,
    input wire logic shadowEnableData,
    input wire logic [priv_pkg::GPR_ADDR_W-1:0] readAddr,
    input wire logic [priv_pkg::DATA_W-1:0] gprReadData,
    input priv_pkg::gpr_write_t gprWriteIn,
    input priv_pkg::scratch_req_t scratchReq,
    input wire logic memTrap,
    input wire logic [priv_pkg::DATA_W-1:0] faultPc,
    input wire logic cacheErrorEvent,
    input wire logic [priv_pkg::DATA_W-1:0] cacheErrorAddrIn,
    input wire logic errorStatusRead,
    output logic [priv_pkg::DATA_W-1:0] readData,
    output priv_pkg::gpr_write_t gprWriteOut,
    output logic [priv_pkg::DATA_W-1:0] scratchReadData,
    output logic scratchReadValid,
    output logic shadowEnable,
    output logic [priv_pkg::DATA_W-1:0] exceptionReturnAddress,
    output logic cacheUnitErrorStatus,
    output logic [priv_pkg::DATA_W-1:0] cacheUnitErrorAddress
);
    // Bank address field cannot reach more slots than this
    if (SCRATCH_COUNT < 1 || SCRATCH_COUNT > (1 << priv_pkg::SCRATCH_ADDR_W))
    begin : g_badScratchCount
        $error("SCRATCH_COUNT out of range");
    end

    // ********************
    // Reset synchroniser
    // ********************
    logic rstMeta;
    logic rstSync;
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rstMeta <= 1'b0;
            rstSync <= 1'b0;
        end
        else
        begin
            rstMeta <= 1'b1;
            rstSync <= rstMeta;
        end
    end
    logic rstN;
    assign rstN = rstSync;

    // ********************
    // Shadow steering
    // ********************
    priv_pkg::shadow_sel_t readSel;
    priv_pkg::shadow_sel_t writeSel;
    shadow_steer uReadSteer
    (
        .regAddr(readAddr),
        .privMode(privMode),
        .shadowEnable(shadowEnable),
        .sel(readSel)
    );
    shadow_steer uWriteSteer
    (
        .regAddr(gprWriteIn.addr),
        .privMode(privMode),
        .shadowEnable(shadowEnable),
        .sel(writeSel)
    );

    logic [priv_pkg::DATA_W-1:0] shadowRegs [priv_pkg::SHADOW_COUNT];
    logic [priv_pkg::DATA_W-1:0] next_shadowRegs [priv_pkg::SHADOW_COUNT];
    logic next_shadowEnable;

    always_comb
    begin
        next_shadowRegs = shadowRegs;
        next_shadowEnable = shadowEnable;
        if (gprWriteIn.valid && writeSel.valid)
            next_shadowRegs[writeSel.idx] = gprWriteIn.data;
        // Change takes effect next cycle; firmware keeps shadows idle meanwhile
        if (shadowEnableWrite)
            next_shadowEnable = shadowEnableData;
    end

    always_ff @(posedge clock or negedge rstN)
    begin
        if (!rstN)
        begin
            shadowRegs <= '{default: priv_pkg::SCRATCH_RESET};
            shadowEnable <= 1'(priv_pkg::SDE_RESET);
        end
        else
        begin
            shadowRegs <= next_shadowRegs;
            shadowEnable <= next_shadowEnable;
        end
    end

    // Overlay hides the normal register from both read and write
    always_comb
    begin
        readData = readSel.valid ? shadowRegs[readSel.idx] : gprReadData;
        gprWriteOut = gprWriteIn;
        gprWriteOut.valid = gprWriteIn.valid && !writeSel.valid;
    end

    // ********************
    // Scratch bank
    // ********************
    logic [priv_pkg::DATA_W-1:0] scratchRegs [SCRATCH_COUNT];
    logic [priv_pkg::DATA_W-1:0] next_scratchRegs [SCRATCH_COUNT];
    logic [priv_pkg::DATA_W-1:0] next_scratchReadData;
    logic next_scratchReadValid;
    logic scratchHit;

    assign scratchHit = 32'(scratchReq.addr) < SCRATCH_COUNT;

    always_comb
    begin
        next_scratchRegs = scratchRegs;
        next_scratchReadData = scratchReadData;
        next_scratchReadValid = 1'b0;
        // Write-then-read spacing is firmware's job; no bypass provided
        if (scratchReq.writeEn && scratchHit)
            next_scratchRegs[scratchReq.addr] = scratchReq.data;
        if (scratchReq.readEn)
        begin
            next_scratchReadValid = 1'b1;
            next_scratchReadData = scratchHit ? scratchRegs[scratchReq.addr] : '0;
        end
    end

    always_ff @(posedge clock or negedge rstN)
    begin
        if (!rstN)
        begin
            scratchRegs <= '{default: priv_pkg::SCRATCH_RESET};
            scratchReadData <= priv_pkg::SCRATCH_RESET;
            scratchReadValid <= 1'b0;
        end
        else
        begin
            scratchRegs <= next_scratchRegs;
            scratchReadData <= next_scratchReadData;
            scratchReadValid <= next_scratchReadValid;
        end
    end

    // ********************
    // Trap return address
    // ********************
    logic [priv_pkg::DATA_W-1:0] next_exceptionReturnAddress;
    // Internal writes near the trap are not cancelled; address capture still wins
    always_comb
    begin
        next_exceptionReturnAddress = exceptionReturnAddress;
        if (memTrap)
            next_exceptionReturnAddress = faultPc;
    end

    always_ff @(posedge clock or negedge rstN)
    begin
        if (!rstN)
            exceptionReturnAddress <= priv_pkg::ADDR_RESET;
        else
            exceptionReturnAddress <= next_exceptionReturnAddress;
    end

    // ********************
    // Cache unit error capture
    // ********************
    logic next_cacheUnitErrorStatus;
    logic [priv_pkg::DATA_W-1:0] next_cacheUnitErrorAddress;
    // Status read unlocks; an error in that same cycle wins so it is not lost
    always_comb
    begin
        next_cacheUnitErrorStatus = cacheUnitErrorStatus;
        next_cacheUnitErrorAddress = cacheUnitErrorAddress;
        if (errorStatusRead)
            next_cacheUnitErrorStatus = 1'b0;
        if (cacheErrorEvent && (!cacheUnitErrorStatus || errorStatusRead))
        begin
            next_cacheUnitErrorStatus = 1'b1;
            next_cacheUnitErrorAddress = cacheErrorAddrIn;
        end
    end

    always_ff @(posedge clock or negedge rstN)
    begin
        if (!rstN)
        begin
            cacheUnitErrorStatus <= 1'b0;
            cacheUnitErrorAddress <= priv_pkg::ADDR_RESET;
        end
        else
        begin
            cacheUnitErrorStatus <= next_cacheUnitErrorStatus;
            cacheUnitErrorAddress <= next_cacheUnitErrorAddress;
        end
    end

    // ********************
    // Assertions
    // ********************
    // Firmware violations stay undefined; nothing interlocks or flags them
    sequence s_scratchWrite;
        scratchReq.writeEn && scratchHit && !scratchReq.readEn;
    endsequence
    property p_scratchLatency;
        @(posedge clock) disable iff (!rstN)
        scratchReq.readEn |=> scratchReadValid;
    endproperty
    a_scratchLatency: assert property (p_scratchLatency) else $error("scratch read not valid next cycle");
    property p_scratchData;
        @(posedge clock) disable iff (!rstN)
        (scratchReq.readEn && scratchHit) |=> scratchReadData == $past(scratchRegs[scratchReq.addr]);
    endproperty
    a_scratchData: assert property (p_scratchData) else $error("scratch read data wrong");
    property p_scratchStore;
        @(posedge clock) disable iff (!rstN)
        s_scratchWrite ##1 (!scratchReq.writeEn) [*3]
            ##1 (scratchReq.readEn && scratchReq.addr == $past(scratchReq.addr, 4))
            |=> scratchReadData == $past(scratchReq.data, 5);
    endproperty
    a_scratchStore: assert property (p_scratchStore) else $error("scratch write lost");
    property p_noSpuriousValid;
        @(posedge clock) disable iff (!rstN)
        !scratchReq.readEn |=> !scratchReadValid;
    endproperty
    a_noSpuriousValid: assert property (p_noSpuriousValid) else $error("spurious scratch valid");
    property p_shadowHidesWrite;
        @(posedge clock) disable iff (!rstN)
        (gprWriteIn.valid && privMode && shadowEnable &&
            (gprWriteIn.addr == priv_pkg::SHADOW_EXTRA_REG)) |-> !gprWriteOut.valid;
    endproperty
    a_shadowHidesWrite: assert property (p_shadowHidesWrite) else $error("shadow write leaked");
    property p_shadowReadBack;
        @(posedge clock) disable iff (!rstN)
        (gprWriteIn.valid && writeSel.valid) |=> shadowRegs[$past(writeSel.idx)] == $past(gprWriteIn.data);
    endproperty
    a_shadowReadBack: assert property (p_shadowReadBack) else $error("shadow not written");
    property p_normalPass;
        @(posedge clock) disable iff (!rstN)
        (!privMode) |-> (readData == gprReadData && gprWriteOut.valid == gprWriteIn.valid);
    endproperty
    a_normalPass: assert property (p_normalPass) else $error("overlay outside privileged mode");
    property p_sdeUpdate;
        @(posedge clock) disable iff (!rstN)
        shadowEnableWrite |=> shadowEnable == $past(shadowEnableData);
    endproperty
    a_sdeUpdate: assert property (p_sdeUpdate) else $error("shadow enable not updated");
    property p_trapPc;
        @(posedge clock) disable iff (!rstN)
        memTrap |=> exceptionReturnAddress == $past(faultPc);
    endproperty
    a_trapPc: assert property (p_trapPc) else $error("return address not captured");
    property p_errorLock;
        @(posedge clock) disable iff (!rstN)
        (cacheUnitErrorStatus && !errorStatusRead) |=> cacheUnitErrorAddress == $past(cacheUnitErrorAddress);
    endproperty
    a_errorLock: assert property (p_errorLock) else $error("locked error address changed");
    property p_errorUnlock;
        @(posedge clock) disable iff (!rstN)
        (errorStatusRead && !cacheErrorEvent) |=> !cacheUnitErrorStatus;
    endproperty
    a_errorUnlock: assert property (p_errorUnlock) else $error("status read did not unlock");
endmodule : priv_scratch_regs

// [tb/fw_stream.sv]
`timescale 1ns/1ps
// Purpose: firmware side issuing scratch moves
// Assumes: bench calls mv between clock edges
// Notes: released lines show inverted values
module fw_stream
(
    input wire logic clock,
    output priv_pkg::scratch_req_t req
);
    // ********************
    // Move task
    // ********************
    initial req = '0;

    // Only scratch moves: no returns, calls, barriers, cache or translation ops

    task automatic mv(input logic wr, input logic [4:0] a, input logic [63:0] d);
    begin
        @(posedge clock);
        req <= '{readEn: !wr, writeEn: wr, addr: a, data: d};
        @(posedge clock);
        req <= '{readEn: 1'b0, writeEn: 1'b0, addr: ~a, data: ~d};
        // Gap so a read never trails its own write
        if (wr)
            repeat (2) @(posedge clock);
    end
    endtask : mv
endmodule : fw_stream

// [tb/priv_scratch_regs_and_ipr_hazards_tb_top.sv]
`timescale 1ns/1ps
// Purpose: self-checking bench for scratch bank and shadows
// Assumes: 200 MHz clock, fixed seed
// Notes: firmware spacing kept by the stream model
module priv_scratch_regs_and_ipr_hazards_tb_top;
    // ********************
    // Signals
    // ********************
    logic clock;
    logic arst_n;
    logic privMode;
    logic shadowEnableWrite;
    logic shadowEnableData;
    logic [4:0] readAddr;
    logic [63:0] gprReadData;
    priv_pkg::gpr_write_t gprWriteIn;
    priv_pkg::scratch_req_t scratchReq;
    logic memTrap;
    logic [63:0] faultPc;
    logic [63:0] readData;
    priv_pkg::gpr_write_t gprWriteOut;
    logic [63:0] scratchReadData;
    logic scratchReadValid;
    logic shadowEnable;
    logic [63:0] exceptionReturnAddress;
    logic cacheErrorEvent;
    logic [63:0] cacheErrorAddrIn;
    logic errorStatusRead;
    logic cacheUnitErrorStatus;
    logic [63:0] cacheUnitErrorAddress;
    logic [63:0] bank [0:31];
    logic [63:0] d;
    logic sh;
    int failures;
    int samples_checked;
    int seed;
    int m;

    priv_scratch_regs DUT
    (
        .clock(clock),
        .arst_n(arst_n),
        .privMode(privMode),
        .shadowEnableWrite(shadowEnableWrite),
        .shadowEnableData(shadowEnableData),
        .readAddr(readAddr),
        .gprReadData(gprReadData),
        .gprWriteIn(gprWriteIn),
        .scratchReq(scratchReq),
        .memTrap(memTrap),
        .faultPc(faultPc),
        .cacheErrorEvent(cacheErrorEvent),
        .cacheErrorAddrIn(cacheErrorAddrIn),
        .errorStatusRead(errorStatusRead),
        .readData(readData),
        .gprWriteOut(gprWriteOut),
        .scratchReadData(scratchReadData),
        .scratchReadValid(scratchReadValid),
        .shadowEnable(shadowEnable),
        .exceptionReturnAddress(exceptionReturnAddress),
        .cacheUnitErrorStatus(cacheUnitErrorStatus),
        .cacheUnitErrorAddress(cacheUnitErrorAddress)
    );

    fw_stream fw
    (
        .clock(clock),
        .req(scratchReq)
    );

    initial
    begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    function automatic logic overlaid(input logic [4:0] a, input logic p, input logic s);
        return p && s && ((a >= 5'h08 && a <= 5'h0E) || a == 5'h19);
    endfunction : overlaid

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    begin
        samples_checked++;
        if (seen !== exp)
        begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    end
    endtask : check

    task automatic tally_and_finish;
    begin
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    end
    endtask : tally_and_finish

    // ********************
    // Main sequence
    // ********************
    initial
    begin
        seed = 61398;
        arst_n = 1'b0;
        privMode = 1'b0;
        shadowEnableWrite = 1'b0;
        shadowEnableData = 1'b1;
        readAddr = 5'h00;
        gprReadData = 64'h0;
        gprWriteIn = '0;
        memTrap = 1'b0;
        faultPc = 64'h0;
        cacheErrorEvent = 1'b0;
        cacheErrorAddrIn = 64'h0;
        errorStatusRead = 1'b0;
        failures = 0;
        samples_checked = 0;
        @(posedge clock);
        #1 check(shadowEnable, 1'b1);
        check(scratchReadValid, 1'b0);
        check(exceptionReturnAddress, 64'h0);
        @(posedge clock);
        arst_n <= 1'b1;
        repeat (3) @(posedge clock);
        // Out-of-range slots are never written and must read back as zero
        for (int i = 0; i < 32; i++)
        begin
            d = {$random(seed), $random(seed)};
            if (i < priv_pkg::SCRATCH_COUNT)
                fw.mv(1'b1, i[4:0], d);
            bank[i] = (i < priv_pkg::SCRATCH_COUNT) ? d : 64'h0;
            #1 check(scratchReadValid, 1'b0);
        end
        for (int i = 31; i >= 0; i--)
        begin
            fw.mv(1'b0, i[4:0], 64'h0);
            #1 check(scratchReadValid, 1'b1);
            check(scratchReadData, bank[i]);
        end
        // Modes: user, shadows off, shadows on
        for (m = 0; m < 3; m++)
        begin
            @(posedge clock);
            privMode <= (m != 0);
            shadowEnableWrite <= 1'b1;
            shadowEnableData <= (m == 2);
            @(posedge clock);
            shadowEnableWrite <= 1'b0;
            repeat (4) @(posedge clock);
            #1 check(shadowEnable, m == 2);
            for (int a = 0; a < 32; a++)
            begin
                @(posedge clock);
                d = {$random(seed), $random(seed)};
                sh = overlaid(a[4:0], m != 0, m == 2);
                gprWriteIn <= '{valid: 1'b1, addr: a[4:0], data: d};
                readAddr <= a[4:0];
                gprReadData <= ~d;
                #1 check(gprWriteOut.valid, !sh);
                check(gprWriteOut.data, d);
                @(posedge clock);
                gprWriteIn <= '{valid: 1'b0, addr: ~a[4:0], data: ~d};
                #1 check(readData, sh ? d : ~d);
                repeat (2) @(posedge clock);
            end
        end
        // Trap beside a scratch write
        d = {$random(seed), $random(seed)};
        fork
            fw.mv(1'b1, 5'h05, d);
            begin
                @(posedge clock);
                memTrap <= 1'b1;
                faultPc <= ~d;
                @(posedge clock);
                memTrap <= 1'b0;
                faultPc <= d;
            end
        join
        #1 check(exceptionReturnAddress, ~d);
        fw.mv(1'b0, 5'h05, 64'h0);
        #1 check(scratchReadData, d);
        // Second error while locked keeps the first address; status read unlocks
        @(posedge clock);
        cacheErrorEvent <= 1'b1;
        cacheErrorAddrIn <= d;
        @(posedge clock);
        cacheErrorAddrIn <= ~d;
        @(posedge clock);
        cacheErrorEvent <= 1'b0;
        #1 check(cacheUnitErrorAddress, d);
        check(cacheUnitErrorStatus, 1'b1);
        @(posedge clock);
        errorStatusRead <= 1'b1;
        @(posedge clock);
        errorStatusRead <= 1'b0;
        #1 check(cacheUnitErrorStatus, 1'b0);
        tally_and_finish();
    end
endmodule : priv_scratch_regs_and_ipr_hazards_tb_top
